// [logic/rtc_cal_defs.svh]
// Operation
// - meridiem bit readable/writable in 12-hour mode
// - 24-hour mode ignores writes of one to meridiem
// - stale meridiem clears at next hour increment
// - hour BCD, 1..12 or 0..23 by mode
// - minute BCD counter, 0..59, read/write
// - month BCD counter, 1..12, read/write
// - day BCD counter honours month lengths
// - weekday counter wraps modulo seven, zero Sunday
// - year BCD counter, 0..99, read/write
// - sticky cause flags, write one clears
// - flag bits 15..12 correction/stopwatch, 11..9 zero
// - flag bits 8..0 alarm down to 1/32 second
// - per-cause enable bit at flag position
`ifndef RTC_CAL_DEFS_SVH
`define RTC_CAL_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define RTC_OFS_HOUR_MINUTE 8'h00
`define RTC_OFS_MONTH_DAY 8'h04
`define RTC_OFS_YEAR_WEEKDAY 8'h08
`define RTC_OFS_FLAGS 8'h0c
`define RTC_OFS_ENABLES 8'h10

// ---------------------------------------------------------------
// field positions and masks
// ---------------------------------------------------------------
`define RTC_MERIDIEM_BIT 14
`define RTC_FLAG_MASK 16'hf1ff
`define RTC_DAY_TICK_BIT 7
`define RTC_HOUR_TICK_BIT 6
`define RTC_MINUTE_TICK_BIT 5

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RTC_RST_HOUR 6'h12
`define RTC_RST_MINUTE 7'h00
`define RTC_RST_MONTH 5'h01
`define RTC_RST_DAY 6'h01
`define RTC_RST_WEEKDAY 3'h0
`define RTC_RST_YEAR 8'h00

`endif

// [logic/rtc_cal_pkg.sv]
`default_nettype none
package rtc_cal_pkg;
  // whole calendar and bus state of the main module
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic meridiem;
    logic [1:0] hour_tens;
    logic [3:0] hour_units;
    logic [2:0] minute_tens;
    logic [3:0] minute_units;
    logic month_tens;
    logic [3:0] month_units;
    logic [1:0] day_tens;
    logic [3:0] day_units;
    logic [2:0] weekday_count;
    logic [3:0] year_tens;
    logic [3:0] year_units;
    logic [15:0] enables;
  } cal_state_t;

  // state of one sticky cause flag
  typedef struct packed {
    logic flag;
  } flag_state_t;
endpackage
`default_nettype wire

// [logic/cause_flag.sv]
`timescale 1ns/10ps
`default_nettype none
module cause_flag
  import rtc_cal_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic set_pulse,  // cause occurred
  input wire logic clear,      // software wrote one
  output logic flag
);
  flag_state_t s;       // registered state
  flag_state_t next_s;  // next state

  // ---------------------------------------------------------------
  // set wins over a clear in the same cycle
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (clear) begin
      next_s.flag = 1'b0;
    end
    if (set_pulse) begin
      next_s.flag = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign flag = s.flag;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  flag_set_a: assert property (@(posedge clk) disable iff (!resetn)
    set_pulse |=> flag)
    else $error("flag not set after cause");
  flag_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    clear && !set_pulse |=> !flag)
    else $error("flag not cleared by write one");
  flag_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !clear && !set_pulse |=> $stable(flag))
    else $error("flag changed without cause");
endmodule
`default_nettype wire

// [logic/rtc_calendar_regs.sv]
`timescale 1ns/10ps
`default_nettype none
`include "rtc_cal_defs.svh"
module rtc_calendar_regs
  import rtc_cal_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic twenty_four_hour_select,  // 1: 24-hour mode
  input wire logic minute_carry,             // one-cycle pulse per minute
  input wire logic [15:0] cause_pulse,       // external cause events
  output logic irq
);
  cal_state_t s;       // registered state
  cal_state_t next_s;  // next state

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic req;        // request pending, not yet answered
  logic bus_write;  // write takes effect at this edge
  logic wr_hm;  // hour/minute write
  logic wr_md;  // month/day write
  logic wr_yw;  // year/weekday write
  logic wr_fl;  // flag clear write
  logic wr_en;  // enable write
  logic [15:0] flags;  // flag register view, read by the bus
  // implemented flag and enable bits, reserved ones zero
  localparam logic [15:0] flag_mask = `RTC_FLAG_MASK;
  assign req = wb_cyc_i && wb_stb_i && !s.ack;
  assign bus_write = wb_cyc_i && wb_stb_i && wb_we_i && s.ack;
  assign wr_hm = bus_write && wb_adr_i == `RTC_OFS_HOUR_MINUTE;
  assign wr_md = bus_write && wb_adr_i == `RTC_OFS_MONTH_DAY;
  assign wr_yw = bus_write && wb_adr_i == `RTC_OFS_YEAR_WEEKDAY;
  assign wr_fl = bus_write && wb_adr_i == `RTC_OFS_FLAGS;
  assign wr_en = bus_write && wb_adr_i == `RTC_OFS_ENABLES;

  // ---------------------------------------------------------------
  // calendar views as BCD bytes
  // ---------------------------------------------------------------
  logic [7:0] hour_bcd, minute_bcd, month_bcd, day_bcd, year_bcd;
  assign hour_bcd = {2'h0, s.hour_tens, s.hour_units};
  assign minute_bcd = {1'h0, s.minute_tens, s.minute_units};
  assign month_bcd = {3'h0, s.month_tens, s.month_units};
  assign day_bcd = {2'h0, s.day_tens, s.day_units};
  assign year_bcd = {s.year_tens, s.year_units};

  // one BCD step of a two-digit value
  function automatic logic [7:0] bcd_step(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_step = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_step = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  logic [7:0] hour_step, minute_step, month_step, day_step, year_step;
  assign hour_step = bcd_step(hour_bcd);
  assign minute_step = bcd_step(minute_bcd);
  assign month_step = bcd_step(month_bcd);
  assign day_step = bcd_step(day_bcd);
  assign year_step = bcd_step(year_bcd);

  // ---------------------------------------------------------------
  // carries between counters
  // ---------------------------------------------------------------
  logic leap_year;      // year divisible by four
  logic [7:0] last_day; // last day of current month
  logic hour_inc, day_inc, month_inc, year_inc;

  // divisible by four in BCD: even tens with 0/4/8, odd with 2/6
  assign leap_year = s.year_tens[0] ?
    (s.year_units == 4'h2 || s.year_units == 4'h6) :
    (s.year_units == 4'h0 || s.year_units == 4'h4 ||
     s.year_units == 4'h8);

  // month length table
  always_comb begin
    unique case (month_bcd)
      8'h02: last_day = leap_year ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  end

  // minute 59 rolls over into the hour counter
  assign hour_inc = minute_carry && minute_bcd == 8'h59;
  // day ends at 23->00, or at 11 p.m.->12 a.m.
  assign day_inc = hour_inc && (twenty_four_hour_select ?
    hour_bcd == 8'h23 : (hour_bcd == 8'h11 && s.meridiem));
  assign month_inc = day_inc && day_bcd == last_day;
  assign year_inc = month_inc && month_bcd == 8'h12;

  // ---------------------------------------------------------------
  // next state: counting, then software writes override
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    // bus answer, one cycle after the request
    next_s.ack = req;
    if (req) begin
      unique case (wb_adr_i)
        `RTC_OFS_HOUR_MINUTE: next_s.rdata = {16'h0, 1'b0, s.meridiem,
          s.hour_tens, s.hour_units, 1'b0, s.minute_tens,
          s.minute_units};
        `RTC_OFS_MONTH_DAY: next_s.rdata = {16'h0, 3'h0, s.month_tens,
          s.month_units, 2'h0, s.day_tens, s.day_units};
        `RTC_OFS_YEAR_WEEKDAY: next_s.rdata = {16'h0, 5'h0,
          s.weekday_count, s.year_tens, s.year_units};
        `RTC_OFS_FLAGS: next_s.rdata = {16'h0, flags};
        `RTC_OFS_ENABLES: next_s.rdata = {16'h0, s.enables};
        default: next_s.rdata = 32'h0;  // unmapped reads zero
      endcase
    end
    // minute counter
    if (minute_carry) begin
      {next_s.minute_tens, next_s.minute_units} = hour_inc ? 7'h00 :
        minute_step[6:0];
    end
    // hour counter and meridiem
    if (hour_inc) begin
      if (twenty_four_hour_select) begin
        next_s.meridiem = 1'b0;
        {next_s.hour_tens, next_s.hour_units} =
          (hour_bcd == 8'h23) ? 6'h00 : hour_step[5:0];
      end else if (hour_bcd == 8'h12) begin
        {next_s.hour_tens, next_s.hour_units} = 6'h01;
      end else begin
        {next_s.hour_tens, next_s.hour_units} = hour_step[5:0];
        if (hour_bcd == 8'h11) begin
          next_s.meridiem = !s.meridiem;
        end
      end
    end
    // day, weekday, month and year
    if (day_inc) begin
      {next_s.day_tens, next_s.day_units} = month_inc ? 6'h01 :
        day_step[5:0];
      next_s.weekday_count = (s.weekday_count == 3'h6) ? 3'h0 :
        s.weekday_count + 3'h1;
    end
    if (month_inc) begin
      {next_s.month_tens, next_s.month_units} = year_inc ? 5'h01 :
        month_step[4:0];
    end
    if (year_inc) begin
      {next_s.year_tens, next_s.year_units} = (year_bcd == 8'h99) ?
        8'h00 : year_step;
    end
    // software writes, per byte lane
    if (wr_hm && wb_sel_i[1]) begin
      // 24-hour mode keeps a one out of the meridiem bit
      next_s.meridiem = wb_dat_i[`RTC_MERIDIEM_BIT] &&
        !twenty_four_hour_select;
      {next_s.hour_tens, next_s.hour_units} = wb_dat_i[13:8];
    end
    if (wr_hm && wb_sel_i[0]) begin
      {next_s.minute_tens, next_s.minute_units} = wb_dat_i[6:0];
    end
    if (wr_md && wb_sel_i[1]) begin
      {next_s.month_tens, next_s.month_units} = wb_dat_i[12:8];
    end
    if (wr_md && wb_sel_i[0]) begin
      {next_s.day_tens, next_s.day_units} = wb_dat_i[5:0];
    end
    if (wr_yw && wb_sel_i[1]) begin
      next_s.weekday_count = wb_dat_i[10:8];
    end
    if (wr_yw && wb_sel_i[0]) begin
      {next_s.year_tens, next_s.year_units} = wb_dat_i[7:0];
    end
    // enables, reserved bits stay zero
    if (wr_en) begin
      if (wb_sel_i[1]) begin
        next_s.enables[15:8] = wb_dat_i[15:8] &
          flag_mask[15:8];
      end
      if (wb_sel_i[0]) begin
        next_s.enables[7:0] = wb_dat_i[7:0];
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      {s.hour_tens, s.hour_units} <= `RTC_RST_HOUR;
      {s.minute_tens, s.minute_units} <= `RTC_RST_MINUTE;
      {s.month_tens, s.month_units} <= `RTC_RST_MONTH;
      {s.day_tens, s.day_units} <= `RTC_RST_DAY;
      s.weekday_count <= `RTC_RST_WEEKDAY;
      {s.year_tens, s.year_units} <= `RTC_RST_YEAR;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // sticky cause flags
  // ---------------------------------------------------------------
  logic [15:0] cause_set;  // external plus calendar ticks
  logic [15:0] flag_clr;   // write-one clear strobes
  logic [15:0] lane_mask;  // written byte lanes
  // clear strobes only from the byte lanes actually written
  assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign flag_clr = wr_fl ? (wb_dat_i[15:0] & lane_mask) : 16'h0;
  // calendar ticks replace pin bits 7..5
  always_comb begin
    cause_set = cause_pulse;
    cause_set[`RTC_MINUTE_TICK_BIT] = minute_carry;
    cause_set[`RTC_HOUR_TICK_BIT] = hour_inc;
    cause_set[`RTC_DAY_TICK_BIT] = day_inc;
  end

  // one cell per implemented flag, reserved bits tied low
  for (genvar i = 0; i < 16; i++) begin : g_flag
    if (flag_mask[i]) begin : g_cell
      cause_flag u_flag (
        .clk(clk),
        .resetn(resetn),
        .set_pulse(cause_set[i]),
        .clear(flag_clr[i]),
        .flag(flags[i])
      );
    end else begin : g_rsvd
      assign flags[i] = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign irq = |(flags & s.enables);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  ack_pulse_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
  meridiem_24h_a: assert property (wr_hm && wb_sel_i[1] &&
    twenty_four_hour_select |=> !s.meridiem)
    else $error("meridiem set in 24-hour mode");
  meridiem_late_a: assert property (hour_inc && !bus_write &&
    twenty_four_hour_select |=> !s.meridiem)
    else $error("meridiem not cleared at hour count");
  hour_wrap_a: assert property (hour_inc && !bus_write &&
    !twenty_four_hour_select && hour_bcd == 8'h12 |=> hour_bcd == 8'h01)
    else $error("12-hour wrap wrong");
  minute_wrap_a: assert property (hour_inc && !bus_write |=>
    minute_bcd == 8'h00 && flags[`RTC_HOUR_TICK_BIT])
    else $error("minute wrap or hour tick wrong");
  month_wrap_a: assert property (year_inc && !bus_write |=>
    month_bcd == 8'h01 ##0 day_bcd == 8'h01)
    else $error("year end month wrap wrong");
  leap_feb_a: assert property (day_inc && !bus_write &&
    month_bcd == 8'h02 && day_bcd == 8'h28 && leap_year |=>
    day_bcd == 8'h29 && month_bcd == 8'h02)
    else $error("leap February ended early");
  short_month_a: assert property (day_inc && !bus_write &&
    month_bcd == 8'h04 && day_bcd == 8'h30 |=> month_bcd == 8'h05)
    else $error("April not ended at 30");
  weekday_wrap_a: assert property (day_inc && !bus_write &&
    s.weekday_count == 3'h6 |=> s.weekday_count == 3'h0)
    else $error("weekday did not wrap to Sunday");
  year_wrap_a: assert property (year_inc && !bus_write &&
    year_bcd == 8'h99 |=> year_bcd == 8'h00)
    else $error("year did not wrap");
  irq_cause_a: assert property ((cause_set & s.enables &
    flag_mask) != 16'h0 && !wr_en |=> irq)
    else $error("enabled cause raised no request");
  irq_blocked_a: assert property (s.enables == 16'h0 |-> !irq)
    else $error("request with all causes disabled");
  meridiem_flip_a: assert property (hour_inc && !bus_write &&
    !twenty_four_hour_select && hour_bcd == 8'h11 |=> s.meridiem != $past(s.meridiem))
    else $error("meridiem not toggled at 11 to 12");
  day_tick_a: assert property (day_inc |=>
    flags[`RTC_DAY_TICK_BIT])
    else $error("day tick flag not set");
  minute_tick_a: assert property (minute_carry |=>
    flags[`RTC_MINUTE_TICK_BIT])
    else $error("minute tick flag not set");

  leap_day_c: cover property (day_inc && month_bcd == 8'h02 &&
    day_bcd == 8'h28 && leap_year);
  pm_to_am_c: cover property (day_inc && !twenty_four_hour_select);
  flag_clear_c: cover property (wr_fl && flags != 16'h0);
  irq_rise_c: cover property ($rose(irq));
  noon_wrap_c: cover property (hour_inc && !twenty_four_hour_select &&
    hour_bcd == 8'h12);
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "rtc_cal_defs.svh"
module tb
  import rtc_cal_pkg::*;
;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  logic clk, resetn, cyc, stb, we, ack, tfh, mcarry, irq;
  logic [7:0] adr;
  logic [3:0] sel, bsel;
  logic [31:0] wdat, rdat, r;
  logic [15:0] cpulse, p, e, c;
  logic [7:0] mo, dy, yr, nm, nd, ny, h, m;
  logic [2:0] wk;
  int mismatches, n_checks;
  // date corner table: month, day, year, weekday
  logic [31:0] dates [8] = '{32'h02282106, 32'h02282403, 32'h02292401,
    32'h04300502, 32'h12319906, 32'h01155000, 32'h11300705, 32'h02280004};
  // 12-hour table: before, after, expected flags
  logic [47:0] h12 [4] = '{48'h5159_1200_00e0, 48'h1159_5200_0060,
    48'h1259_0100_0060, 48'h5259_4100_0060};

  rtc_calendar_regs dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .twenty_four_hour_select(tfh), .minute_carry(mcarry),
    .cause_pulse(cpulse), .irq(irq));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task test_done;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one classic wishbone cycle, waits for ack under a bound
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= bsel;
    wdat <= {16'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      mismatches++;
      test_done();
    end
  endtask

  // read and compare full word, upper half zero
  task rchk(input logic [7:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0);
    chk(r, {16'h0, exp});
  endtask

  // one minute carry pulse, never while a write is in flight
  task carry;
    @(posedge clk);
    mcarry <= 1'b1;
    @(posedge clk);
    mcarry <= 1'b0;
  endtask

  // bcd increment of two digits
  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h1;
  endfunction

  // binary to two bcd digits
  function automatic logic [7:0] bcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction

  // last day of a month, leap when year divisible by four
  function automatic logic [7:0] last_day(input logic [7:0] mm,
                                          input logic [7:0] yy);
    int yv;
    yv = yy[7:4] * 10 + yy[3:0];
    if (mm == 8'h02) return (yv % 4 == 0) ? 8'h29 : 8'h28;
    if (mm == 8'h04 || mm == 8'h06 || mm == 8'h09 || mm == 8'h11)
      return 8'h30;
    return 8'h31;
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h0cf70465));
    mismatches = 0;
    n_checks = 0;
    {resetn, cyc, stb, we, tfh, mcarry} = '0;
    {adr, sel, wdat, cpulse} = '0;
    bsel = 4'h3;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    // reset values and an unmapped place
    rchk(`RTC_OFS_HOUR_MINUTE, 16'h1200);
    rchk(`RTC_OFS_MONTH_DAY, 16'h0101);
    rchk(`RTC_OFS_YEAR_WEEKDAY, 16'h0000);
    rchk(`RTC_OFS_FLAGS, 16'h0000);
    rchk(`RTC_OFS_ENABLES, 16'h0000);
    bus(1'b1, 8'h40, 16'hffff);
    rchk(8'h40, 16'h0000);
    // random read back and minute counting in 12-hour mode
    for (int i = 0; i < 8; i++) begin
      h = bcd(1 + $urandom_range(11));
      m = bcd($urandom_range(58));
      p = {1'b0, 1'($urandom), h[5:0], 1'b0, m[6:0]};
      bus(1'b1, `RTC_OFS_HOUR_MINUTE, p);
      rchk(`RTC_OFS_HOUR_MINUTE, p);
      carry();
      rchk(`RTC_OFS_HOUR_MINUTE, {p[15:8], inc(m)});
      p = {5'h0, 3'($urandom_range(6)), bcd($urandom_range(99))};
      bus(1'b1, `RTC_OFS_YEAR_WEEKDAY, p);
      rchk(`RTC_OFS_YEAR_WEEKDAY, p);
      // month drawn from 1..12, never zero
      p = {bcd(1 + $urandom_range(11)), bcd(1 + $urandom_range(27))};
      bus(1'b1, `RTC_OFS_MONTH_DAY, p);
      rchk(`RTC_OFS_MONTH_DAY, p);
    end
    // hour roll-overs in 12-hour mode
    foreach (h12[i]) begin
      bus(1'b1, `RTC_OFS_FLAGS, 16'hffff);
      bus(1'b1, `RTC_OFS_HOUR_MINUTE, h12[i][47:32]);
      carry();
      rchk(`RTC_OFS_HOUR_MINUTE, h12[i][31:16]);
      rchk(`RTC_OFS_FLAGS, h12[i][15:0]);
    end
    // stale meridiem survives the switch, clears at the hour step
    bus(1'b1, `RTC_OFS_HOUR_MINUTE, 16'h4559);
    @(posedge clk);
    tfh <= 1'b1;
    rchk(`RTC_OFS_HOUR_MINUTE, 16'h4559);
    carry();
    rchk(`RTC_OFS_HOUR_MINUTE, 16'h0600);
    bus(1'b1, `RTC_OFS_HOUR_MINUTE, 16'h5310);
    rchk(`RTC_OFS_HOUR_MINUTE, 16'h1310);
    // minute lane alone, hour lane left as it was
    bsel = 4'h1;
    bus(1'b1, `RTC_OFS_HOUR_MINUTE, 16'h2245);
    bsel = 4'h3;
    rchk(`RTC_OFS_HOUR_MINUTE, 16'h1345);
    // day, month, year and weekday roll-overs from 23:59
    foreach (dates[i]) begin
      {mo, dy, yr} = dates[i][31:8];
      wk = dates[i][2:0];
      bus(1'b1, `RTC_OFS_HOUR_MINUTE, 16'h2359);
      bus(1'b1, `RTC_OFS_MONTH_DAY, {mo, dy});
      bus(1'b1, `RTC_OFS_YEAR_WEEKDAY, {5'h0, wk, yr});
      bus(1'b1, `RTC_OFS_FLAGS, 16'hffff);
      carry();
      nd = (dy == last_day(mo, yr)) ? 8'h01 : inc(dy);
      nm = (nd != 8'h01) ? mo : (mo == 8'h12) ? 8'h01 : inc(mo);
      ny = (nd != 8'h01 || mo != 8'h12) ? yr :
        (yr == 8'h99) ? 8'h00 : inc(yr);
      rchk(`RTC_OFS_HOUR_MINUTE, 16'h0000);
      rchk(`RTC_OFS_MONTH_DAY, {nm, nd});
      wk = (wk == 3'h6) ? 3'h0 : wk + 3'h1;
      rchk(`RTC_OFS_YEAR_WEEKDAY, {5'h0, wk, ny});
      rchk(`RTC_OFS_FLAGS, 16'h00e0);
    end
    // sticky flags, write-one clear, enables and request line
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `RTC_OFS_FLAGS, 16'hffff);
      rchk(`RTC_OFS_FLAGS, 16'h0000);
      p = (i == 0) ? 16'hffff : 16'($urandom);
      e = (i == 0) ? 16'hffff : 16'($urandom);
      c = 16'($urandom);
      @(posedge clk);
      cpulse <= p;
      @(posedge clk);
      cpulse <= 16'h0;
      p = p & 16'hf11f;
      repeat (3) @(posedge clk);
      rchk(`RTC_OFS_FLAGS, p);
      bus(1'b1, `RTC_OFS_FLAGS, 16'h0000);
      rchk(`RTC_OFS_FLAGS, p);
      bus(1'b1, `RTC_OFS_ENABLES, e);
      rchk(`RTC_OFS_ENABLES, e & `RTC_FLAG_MASK);
      @(negedge clk);
      chk(irq, |(p & e & `RTC_FLAG_MASK));
      bus(1'b1, `RTC_OFS_FLAGS, c);
      rchk(`RTC_OFS_FLAGS, p & ~c);
      @(negedge clk);
      chk(irq, |(p & ~c & e & `RTC_FLAG_MASK));
    end
    test_done();
  end
endmodule
`default_nettype wire
